// [rtl/bcc_core.v]
`include "bcc_map.vh"
// How it works
// RULE1 - branch-if-zero word e0nn branches only while the zero flag is one
// RULE2 - taken branch target is incremented pc plus twice sign-extended offset
// RULE3 - branch: one cycle untaken, two taken; pc written q4; flags untouched
// RULE4 - call pushes pc plus four into the return stack top
// RULE5 - call loads 20-bit literal into pc bits 20:1; flags untouched
// RULE6 - call with s set copies working, flags, bank registers into shadows
// RULE7 - call first word holds low literal, second word 1111 plus high literal
// RULE8 - call: low literal q2, push q3, high literal and pc write q4
// RULE9 - clear op writes zero to addressed register and sets zero flag
// RULE10 - a zero selects access bank, a one uses bank select register
// RULE11 - a zero with extended set and address up to 5fh uses indexed offset
// RULE12 - taken branch or call discards prefetched word; nop cycle refills
module bcc_core #(
    parameter PC_W = 21,
    parameter DATA_W = 8
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [15:0] instr_word_in,        // word fetched at pc
    input wire [15:0] next_word_in,         // prefetched following word
    input wire ext_set_en_in,               // extended instruction set on
    input wire [7:0] index_base_in,         // index register low byte for offset mode
    input wire [DATA_W-1:0] working_reg_in,
    input wire [DATA_W-1:0] flags_reg_in,
    output reg [PC_W-1:0] pc_out,
    output wire [3:0] phase_out,
    output reg [PC_W-1:0] return_stack_top_out,
    output reg stack_push_out,
    output reg [DATA_W-1:0] working_register_shadow_out,
    output reg [DATA_W-1:0] flags_register_shadow_out,
    output reg [3:0] bank_select_register_out,
    output reg [3:0] bank_select_shadow_out,
    output reg zero_flag_out,
    output reg zero_flag_wr_out,
    output reg data_wr_out,
    output reg [11:0] data_addr_out,
    output reg [DATA_W-1:0] data_wdata_out,
    output reg flush_out,
    output reg nop_cycle_out
);
    // ----------------------------------------
    // phase generator
    // ----------------------------------------
    wire [3:0] q;
    bcc_qgen u_qgen (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .phase_out(q)
    );
    assign phase_out = q;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // one-hot cycle states: normal execute and pipeline refill
    localparam ST_EXEC = 2'h1;
    localparam ST_NOP = 2'h2;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [15:0] ir_q;       // word latched at q1
    reg [7:0] lit_lo_q;    // call low literal / branch offset, read q2
    // opcode match for the three supported ops
    wire is_brz = (ir_q[15:8] == `BCC_OP_BRZ);
    wire is_call = (ir_q[15:9] == `BCC_OP_CALL_HI) && (next_word_in[15:12] == `BCC_OP_CALL2_HI); // RULE7
    wire is_clr = (ir_q[15:9] == `BCC_OP_CLR_HI);
    // operand fields of the latched word
    wire call_save = ir_q[8];
    wire clr_access = ~ir_q[8];
    wire [7:0] faddr = ir_q[7:0];
    // branch decision and jump targets
    wire taken = is_brz && zero_flag_out; // RULE1
    wire [PC_W-1:0] pc_inc = pc_out + `BCC_PC_STEP;
    wire [PC_W-1:0] offs2 = {{(PC_W-9){lit_lo_q[7]}}, lit_lo_q, 1'b0};
    wire [PC_W-1:0] br_target = pc_inc + offs2; // RULE2
    wire [19:0] call_lit = {next_word_in[11:0], lit_lo_q}; // RULE7
    wire [PC_W-1:0] call_target = {call_lit, 1'b0}; // RULE5
    // return address skips both words of the call
    wire [PC_W-1:0] ret_addr = pc_out + `BCC_RET_STEP; // RULE4

    // clear-op address selection
    reg [11:0] clr_addr;
    always @* begin
        if (!clr_access) begin
            clr_addr = {bank_select_register_out, faddr}; // RULE10
        end else if (ext_set_en_in && (faddr <= `BCC_ILO_LIMIT)) begin
            clr_addr = {4'h0, faddr + index_base_in}; // RULE11
        end else if (faddr < `BCC_ACCESS_SPLIT) begin
            clr_addr = {4'h0, faddr}; // RULE10
        end else begin
            clr_addr = {`BCC_SFR_BANK, faddr}; // RULE10
        end
    end

    // ----------------------------------------
    // cycle state
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (q[3] && (taken || is_call)) begin
                    state_d = ST_NOP; // RULE3 RULE8 RULE12
                end
            end
            ST_NOP: begin
                if (q[3]) begin
                    state_d = ST_EXEC;
                end
            end
            default: state_d = ST_EXEC;
        endcase
    end

    // ----------------------------------------
    // cycle state register
    // ----------------------------------------
    // state_q only moves on the q4 edge, so the refill lasts a whole cycle
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q <= ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // fetch and literal latches
    // ----------------------------------------
    // word latched at q1; a refill cycle latches an all-zero word so nothing executes
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            ir_q <= 16'h0000;
            lit_lo_q <= 8'h00;
            nop_cycle_out <= 1'b0;
        end else begin
            if (q[0]) begin
                nop_cycle_out <= (state_q == ST_NOP);
                ir_q <= (state_q == ST_NOP) ? 16'h0000 : instr_word_in; // RULE12
            end
            // low literal or branch offset captured in the second quarter
            if (q[1] && state_q == ST_EXEC) begin
                lit_lo_q <= ir_q[7:0]; // RULE8
            end
        end
    end

    // ----------------------------------------
    // return stack and shadow copies
    // ----------------------------------------
    // push lands on the q3 edge, before the pc is overwritten on q4
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            return_stack_top_out <= {PC_W{1'b0}};
            stack_push_out <= 1'b0;
            working_register_shadow_out <= {DATA_W{1'b0}};
            flags_register_shadow_out <= {DATA_W{1'b0}};
            bank_select_shadow_out <= 4'h0;
        end else begin
            stack_push_out <= 1'b0;
            if (q[2] && state_q == ST_EXEC && is_call) begin
                return_stack_top_out <= ret_addr; // RULE4 RULE8
                stack_push_out <= 1'b1;
                // shadows only move when the s bit asks for it
                if (call_save) begin
                    working_register_shadow_out <= working_reg_in; // RULE6
                    flags_register_shadow_out <= flags_reg_in; // RULE6
                    bank_select_shadow_out <= bank_select_register_out; // RULE6
                end
            end
        end
    end

    // ----------------------------------------
    // program counter and pipeline flush
    // ----------------------------------------
    // pc written on the q4 edge only; a refill cycle leaves it alone
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            pc_out <= {PC_W{1'b0}};
            flush_out <= 1'b0;
        end else begin
            flush_out <= 1'b0;
            if (q[3] && state_q == ST_EXEC) begin
                if (is_call) begin
                    pc_out <= call_target; // RULE5 RULE8
                    flush_out <= 1'b1; // RULE12
                end else if (taken) begin
                    pc_out <= br_target; // RULE2 RULE3
                    flush_out <= 1'b1; // RULE12
                end else begin
                    pc_out <= pc_inc; // RULE3
                end
            end
        end
    end

    // ----------------------------------------
    // clear-op data write and zero flag
    // ----------------------------------------
    // the bank register is not loaded by these three ops and keeps its reset value
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            bank_select_register_out <= 4'h0;
            zero_flag_out <= 1'b0;
            zero_flag_wr_out <= 1'b0;
            data_wr_out <= 1'b0;
            data_addr_out <= 12'h000;
            data_wdata_out <= {DATA_W{1'b0}};
        end else begin
            zero_flag_wr_out <= 1'b0;
            data_wr_out <= 1'b0;
            // write strobe and flag update share the q4 edge
            if (q[3] && state_q == ST_EXEC && is_clr) begin
                data_wr_out <= 1'b1; // RULE9
                data_addr_out <= clr_addr;
                data_wdata_out <= {DATA_W{1'b0}}; // RULE9
                zero_flag_out <= 1'b1; // RULE9
                zero_flag_wr_out <= 1'b1;
            end
        end
    end
endmodule // bcc_core

// [rtl/bcc_map.vh]
`ifndef BCC_MAP_VH
`define BCC_MAP_VH
// ----------------------------------------
// opcode fields (upper bits of the word)
// ----------------------------------------
`define BCC_OP_BRZ 8'he0
`define BCC_OP_CALL_HI 7'h76
`define BCC_OP_CALL2_HI 4'hf
`define BCC_OP_CLR_HI 7'h35
// ----------------------------------------
// addressing constants
// ----------------------------------------
`define BCC_ILO_LIMIT 8'h5f
`define BCC_ACCESS_SPLIT 8'h60
`define BCC_SFR_BANK 4'hf
`define BCC_PC_STEP 21'h000002
`define BCC_RET_STEP 21'h000004
// ----------------------------------------
// quarter-cycle phase codes (one-hot)
// ----------------------------------------
`define BCC_Q1 4'h1
`define BCC_Q2 4'h2
`define BCC_Q3 4'h4
`define BCC_Q4 4'h8
`endif

// [rtl/bcc_qgen.v]
`include "bcc_map.vh"
// quarter-cycle phase generator: one-hot ring q1..q4
module bcc_qgen (
    input wire clk_in,
    input wire sys_rst_in,
    output reg [3:0] phase_out
);
    // ----------------------------------------
    // ring rotation
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase_out <= `BCC_Q1;
        end else begin
            phase_out <= {phase_out[2:0], phase_out[3]};
        end
    end
endmodule // bcc_qgen

// [verification/bcc_core_assertions.sv]
// checker on the core ports, bound into every bcc_core
module bcc_core_chk (
    input wire clk_in, input wire sys_rst_in, input wire [3:0] phase_out, input wire [20:0] pc_out,
    input wire [20:0] return_stack_top_out, input wire stack_push_out, input wire zero_flag_out,
    input wire zero_flag_wr_out, input wire data_wr_out, input wire [7:0] data_wdata_out,
    input wire flush_out, input wire nop_cycle_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_ring; phase_out == 4'h1 |=> phase_out == 4'h2; endproperty
    a_ring: assert property (p_ring) else $error("phase ring broken");
    property p_push; stack_push_out |-> $past(phase_out) == 4'h4; endproperty
    a_push: assert property (p_push) else $error("push outside third quarter");
    property p_ret; stack_push_out |-> return_stack_top_out == pc_out + 21'h4; endproperty
    a_ret: assert property (p_ret) else $error("pushed return address wrong");
    property p_pcq; $changed(pc_out) |-> $past(phase_out) == 4'h8; endproperty
    a_pcq: assert property (p_pcq) else $error("pc written outside fourth quarter");
    property p_clr; data_wr_out |-> data_wdata_out == 8'h00 && zero_flag_out; endproperty
    a_clr: assert property (p_clr) else $error("clear wrote nonzero or left zero flag");
    property p_zwr; zero_flag_wr_out |-> data_wr_out; endproperty
    a_zwr: assert property (p_zwr) else $error("zero flag written without clear");
    property p_zst; $changed(zero_flag_out) |-> $past(zero_flag_wr_out) || zero_flag_wr_out; endproperty
    a_zst: assert property (p_zst) else $error("zero flag moved on its own");
    property p_nop; flush_out |=> nop_cycle_out [*3]; endproperty
    a_nop: assert property (p_nop) else $error("no refill cycle after flush");
endmodule // bcc_core_chk
bind bcc_core bcc_core_chk u_chk (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .phase_out(phase_out),
    .pc_out(pc_out),
    .return_stack_top_out(return_stack_top_out),
    .stack_push_out(stack_push_out),
    .zero_flag_out(zero_flag_out),
    .zero_flag_wr_out(zero_flag_wr_out),
    .data_wr_out(data_wr_out),
    .data_wdata_out(data_wdata_out),
    .flush_out(flush_out),
    .nop_cycle_out(nop_cycle_out)
);

// [verification/bcc_core_test.sv]
// bench for the branch, call and clear decoder
module bcc_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, sys_rst_in = 1, ext_set_en_in = 0;
    logic [15:0] instr_word_in = 0, next_word_in = 0;
    logic [7:0] index_base_in = 0, working_reg_in = 0, flags_reg_in = 0;
    wire [20:0] pc_out, return_stack_top_out;
    wire [3:0] phase_out, bank_select_register_out, bank_select_shadow_out;
    wire [7:0] working_register_shadow_out, flags_register_shadow_out, data_wdata_out;
    wire [11:0] data_addr_out;
    wire stack_push_out, zero_flag_out, zero_flag_wr_out, data_wr_out, flush_out, nop_cycle_out;
    logic [20:0] pc_e = 0;
    int err_total = 0, compares = 0;
    int stall_n = 0; // extra clocks exec waited for a decoding q1
    bcc_core u_dut (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .instr_word_in(instr_word_in),
        .next_word_in(next_word_in),
        .ext_set_en_in(ext_set_en_in),
        .index_base_in(index_base_in),
        .working_reg_in(working_reg_in),
        .flags_reg_in(flags_reg_in),
        .pc_out(pc_out),
        .phase_out(phase_out),
        .return_stack_top_out(return_stack_top_out),
        .stack_push_out(stack_push_out),
        .working_register_shadow_out(working_register_shadow_out),
        .flags_register_shadow_out(flags_register_shadow_out),
        .bank_select_register_out(bank_select_register_out),
        .bank_select_shadow_out(bank_select_shadow_out),
        .zero_flag_out(zero_flag_out),
        .zero_flag_wr_out(zero_flag_wr_out),
        .data_wr_out(data_wr_out),
        .data_addr_out(data_addr_out),
        .data_wdata_out(data_wdata_out),
        .flush_out(flush_out),
        .nop_cycle_out(nop_cycle_out)
    );
    initial forever #10 clk_in = ~clk_in;
    task close_out;
        $display("counts: %0d mismatches, %0d compares", err_total, compares);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task ck(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // entered on the negedge before a q1 edge; hold the word through any refill cycle, return after its q4
    task exec(input logic [15:0] w, input logic [15:0] nw);
        int n;
        n = 0;
        instr_word_in = w;
        next_word_in = nw;
        @(negedge clk_in);
        while (!(phase_out === 4'h2 && nop_cycle_out === 1'b0)) begin
            n++;
            if (n > 20) begin ck(1'b0, "wait ran out"); close_out(); end
            @(negedge clk_in);
        end
        stall_n = n;
        repeat (3) @(negedge clk_in);
    endtask
    task t_untaken;
        exec(16'he005, 16'h0000);
        pc_e = pc_e + 21'h2;
        ck(pc_out === pc_e && zero_flag_out === 1'b0, "untaken branch moved pc");
        ck(flush_out === 1'b0, "untaken branch flushed");
        $display("untaken branch done");
    endtask
    task t_clear;
        ext_set_en_in = 1;
        index_base_in = 8'h20;
        exec(16'h6a10, 16'h0000);
        ck(stall_n === 0, "untaken branch stalled");
        ck(data_wr_out === 1'b1 && data_wdata_out === 8'h00, "clear wrote nothing");
        ck(data_addr_out === 12'h030 && zero_flag_out === 1'b1, "offset clear address");
        exec(16'h6a60, 16'h0000);
        ck(data_addr_out === 12'hf60, "access bank above offset range");
        exec(16'h6b10, 16'h0000);
        ck(data_addr_out === 12'h010, "banked clear address");
        pc_e = pc_e + 21'h6;
        ck(pc_out === pc_e, "clear took more than one word");
        $display("clear done");
    endtask
    task t_branch;
        exec(16'he07f, 16'h0000);
        pc_e = pc_e + 21'h2 + 21'd254;
        ck(pc_out === pc_e && flush_out === 1'b1, "forward branch");
        exec(16'he080, 16'h0000);
        ck(stall_n === 4, "taken branch skipped its refill cycle");
        pc_e = pc_e + 21'h2 - 21'd256;
        ck(pc_out === pc_e && zero_flag_out === 1'b1, "backward branch");
        $display("taken branch done");
    endtask
    task t_call;
        working_reg_in = 8'ha5;
        flags_reg_in = 8'h3c;
        exec(16'hed34, 16'hf123);
        ck(stall_n === 4, "backward branch skipped its refill cycle");
        ck(return_stack_top_out === pc_e + 21'h4, "call return address");
        ck(pc_out === 21'h024668 && flush_out === 1'b1, "call target");
        ck(working_register_shadow_out === 8'ha5 && flags_register_shadow_out === 8'h3c, "shadow save");
        working_reg_in = 8'h11;
        exec(16'hec00, 16'hf000);
        ck(stall_n === 4, "call skipped its refill cycle");
        ck(return_stack_top_out === 21'h02466c && pc_out === 21'h000000, "second call");
        ck(working_register_shadow_out === 8'ha5, "shadow changed with s clear");
        $display("call done");
    endtask
    // reset for twenty cycles, then the scenarios in order
    initial begin
        repeat (20) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 0;
        t_untaken();
        t_clear();
        t_branch();
        t_call();
        close_out();
    end
endmodule // bcc_core_test
